// File: common/mdr_pkg.sv
package mdr_pkg;
    // register map, 8-bit data at the field's own register number
    localparam logic [7:0] REG_TOPSPD = 8'h0e;
    localparam logic [7:0] REG_LIMSEL = 8'h10;
    localparam logic [7:0] REG_RAMP = 8'h11;
    localparam logic [7:0] REG_CTRL = 8'h30;
    localparam logic [7:0] REG_DUTY = 8'h31;
    localparam logic [7:0] REG_CLIM = 8'h32;
    localparam logic [7:0] REG_STAT = 8'h33;
    localparam logic [7:0] RST_VAL = 8'h00;
    // field positions
    localparam int TOPSPD_LSB = 1;
    localparam int RUNSTEP_LSB = 4;
    localparam int STFRAC_LSB = 1;
    localparam int ADD_LSB = 6;
    localparam int UP_LSB = 4;
    localparam int SSSTEP_LSB = 1;
    localparam int UPTIME_BIT = 0;
    localparam int LIMEN_BIT = 0;
    // duty: 9 integer bits of 1/512 plus 3 bits of eighths
    localparam int DUTY_W = 12;
    localparam int FRAC_W = 3;
    localparam logic [DUTY_W-1:0] DUTY_MAX = 12'hfff;
    localparam logic [6:0] UNLIMITED_STEP = 7'h40; // 8 counts in eighths
    // current limit in per-mille of full scale
    localparam logic [9:0] CLIM_FULL = 10'h3e8; // 1000
    localparam logic [9:0] CLIM_FRAC_STEP = 10'h07d; // 125 = 12.5 %
    // timing
    localparam int CLK_NS = 25;
    localparam int T_FAST_NS = 2700000;
    localparam int T_SLOW_NS = 10800000;
    localparam int T_CLIM_NS = 350000000;
    localparam int FAST_CYC = T_FAST_NS / CLK_NS;
    localparam int SLOW_CYC = T_SLOW_NS / CLK_NS;
    localparam int CLIM_CYC = T_CLIM_NS / CLK_NS;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SOFT = 2'b01,
        ST_SENSL = 2'b11
    } mdr_state_e;
endpackage

// File: common/mdr_tick_if.sv
`timescale 1ns/10ps
// restartable periodic tick between the core and its interval timers
interface mdr_tick_if;
    logic restart;
    logic tick;
    modport src(input restart, output tick);
    modport usr(output restart, input tick);
endinterface

// File: core/mdr_tick.sv
`timescale 1ns/10ps
module mdr_tick
    import mdr_pkg::*;
#(
    parameter int PERIOD = 108000,
    parameter int CW = 24
) (
    input wire logic sys_clk,
    input wire logic nrst,
    mdr_tick_if.src t
);

    logic [CW-1:0] cnt_q;
    logic tick_q;

    generate
        if (PERIOD < 1 || PERIOD > (2 ** CW)) begin : g_bad
            $error("mdr_tick period out of range");
        end
    endgenerate

    // count from restart; tick is one cycle wide at the end of each period
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (t.restart) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (cnt_q == CW'(PERIOD - 1)) begin
            cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    assign t.tick = tick_q;
endmodule

// File: core/mdr_core.sv
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
// How it works
// R1: startup duty rises from zero until current limit
// R2: limit enabled: soft-start step from table
// R3: limit disabled: eight counts per 2.7 ms
// R4: sensorless step moves limit toward normal
// R5: after wait, step limit every 350 ms
// R6: ramped limit never exceeds normal limit
// R7: additional field sets ramp target above startup
// R8: increment field sets each ramp step size
// R9: idling forward skips startup, normal limit
// R10: idle start duty is speed/top speed/2
// R11: top speed field picks 4096 to 32768 rpm
// R12: sensorless speed set by limited duty change
// R13: interval field picks 2.7 ms or 10.8 ms
// R14: run step table; code zero open/closed loop
// R15: interval and step chosen by drive phase
// R16: startup limit is fraction until sensorless
// R17: duty kept with three fractional bits
module mdr_core
    import mdr_pkg::*;
#(
    parameter int FAST_CYCLES = FAST_CYC,
    parameter int SLOW_CYCLES = SLOW_CYC,
    parameter int CLIM_CYCLES = CLIM_CYC
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic spd_cmd,
    input wire logic idling_fwd,
    input wire logic [15:0] idle_rpm,
    input wire logic sensl_reached,
    input wire logic at_stable,
    input wire logic closed_loop,
    input wire logic [8:0] target_duty,
    input wire logic cur_hit_pin,
    output logic [8:0] duty_out,
    output logic [9:0] cur_limit,
    output logic [1:0] drive_state
);
    logic [7:0] topspd_q;
    logic [7:0] limsel_q;
    logic [7:0] ramp_q;
    logic [7:0] ctrl_q;
    logic [7:0] rdata_q;
    logic cur_sync1_q;
    logic cur_sync2_q;
    mdr_state_e st_q;
    logic [DUTY_W-1:0] duty_q;
    logic [DUTY_W-1:0] duty_d;
    logic [9:0] clim_q;
    logic ramp_wait_q;
    logic [6:0] ss_step;
    logic [6:0] run_step;
    logic [9:0] start_lim;
    logic [9:0] add_amt;
    logic [9:0] up_amt;
    logic [10:0] ramp_tgt;
    logic [9:0] ramp_cap;
    logic [10:0] ramp_next;
    logic [DUTY_W-1:0] idle_duty;
    logic [DUTY_W-1:0] run_tgt;
    logic [DUTY_W:0] soft_sum;
    logic [DUTY_W-1:0] gap;
    logic use_slow;
    logic run_tick;
    logic soft_start;

    mdr_tick_if fast_if();
    mdr_tick_if slow_if();
    mdr_tick_if clim_if();

    // fast and slow interval timers restart only on a start from idle, so intervals align to it
    mdr_tick #(.PERIOD(FAST_CYCLES), .CW(24)) u_fast (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .t(fast_if.src)
    );
    mdr_tick #(.PERIOD(SLOW_CYCLES), .CW(24)) u_slow (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .t(slow_if.src)
    );
    mdr_tick #(.PERIOD(CLIM_CYCLES), .CW(24)) u_clim (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .t(clim_if.src)
    );

    assign soft_start = (st_q == ST_IDLE) && spd_cmd;
    assign fast_if.restart = soft_start;
    assign slow_if.restart = soft_start;
    // free-running limit timer: first tick ends the wait, so wait is 0 to one period
    assign clim_if.restart = 1'b0;

    // current comparator is asynchronous to sys_clk
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cur_sync1_q <= 1'b0;
            cur_sync2_q <= 1'b0;
        end else begin
            cur_sync1_q <= cur_hit_pin;
            cur_sync2_q <= cur_sync1_q;
        end
    end

    // register writes
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            topspd_q <= RST_VAL;
            limsel_q <= RST_VAL;
            ramp_q <= RST_VAL;
            ctrl_q <= RST_VAL;
        end else if (reg_wr) begin
            case (reg_addr)
                REG_TOPSPD: topspd_q <= reg_wdata;
                REG_LIMSEL: limsel_q <= reg_wdata;
                REG_RAMP: ramp_q <= reg_wdata;
                REG_CTRL: ctrl_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // read data stands one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= RST_VAL;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_TOPSPD: rdata_q <= topspd_q;
                REG_LIMSEL: rdata_q <= limsel_q;
                REG_RAMP: rdata_q <= ramp_q;
                REG_CTRL: rdata_q <= ctrl_q;
                REG_DUTY: rdata_q <= duty_q[DUTY_W-1:FRAC_W+1];
                REG_CLIM: rdata_q <= clim_q[9:2];
                REG_STAT: rdata_q <= {4'h0, ramp_wait_q, cur_sync2_q, st_q};
                default: rdata_q <= RST_VAL;
            endcase
        end else begin
            rdata_q <= RST_VAL;
        end
    end

    // soft-start step in eighths of a count
    always_comb begin
        if (!ctrl_q[LIMEN_BIT]) begin
            ss_step = UNLIMITED_STEP; // R3
        end else begin
            case (ramp_q[SSSTEP_LSB +: 3]) // R2
                3'h0: ss_step = 7'h40;
                3'h1: ss_step = 7'h02;
                3'h2: ss_step = 7'h03;
                3'h3: ss_step = 7'h04;
                3'h4: ss_step = 7'h06;
                3'h5: ss_step = 7'h0a;
                3'h6: ss_step = 7'h14;
                default: ss_step = 7'h38;
            endcase
        end
    end

    // run step; code zero in closed loop is 64/8, open loop handled as no limit
    always_comb begin
        case (limsel_q[RUNSTEP_LSB +: 3]) // R14
            3'h1: run_step = 7'h02;
            3'h2: run_step = 7'h03;
            3'h3: run_step = 7'h04;
            3'h4: run_step = 7'h06;
            3'h5: run_step = 7'h0a;
            3'h6: run_step = 7'h14;
            3'h7: run_step = 7'h38;
            default: run_step = 7'h40;
        endcase
    end

    // current limit figures in per-mille of full scale
    always_comb begin
        start_lim = 10'(CLIM_FULL - 10'(CLIM_FRAC_STEP * limsel_q[STFRAC_LSB +: 3])); // R16
        case (ramp_q[ADD_LSB +: 2]) // R7
            2'h1: add_amt = 10'h12c;
            2'h2: add_amt = 10'h190;
            2'h3: add_amt = 10'h1f4;
            default: add_amt = 10'h000;
        endcase
        case (ramp_q[UP_LSB +: 2]) // R8
            2'h1: up_amt = 10'h014;
            2'h2: up_amt = 10'h032;
            2'h3: up_amt = 10'h064;
            default: up_amt = 10'h00a;
        endcase
        ramp_tgt = {1'b0, start_lim} + {1'b0, add_amt};
        ramp_cap = (ramp_tgt > {1'b0, CLIM_FULL}) ? CLIM_FULL : ramp_tgt[9:0]; // R6
        ramp_next = {1'b0, clim_q} + {1'b0, up_amt};
    end

    // eighths = rpm * 4096 / (4096 << sel) / 2, saturated at full duty
    always_comb begin
        logic [15:0] q;
        // shift amount is three bits wide so that code 3 shifts by four, not by zero
        q = idle_rpm >> ({1'b0, topspd_q[TOPSPD_LSB +: 2]} + 3'd1); // R10 R11
        idle_duty = (q > 16'(DUTY_MAX)) ? DUTY_MAX : q[DUTY_W-1:0];
    end

    // interval choice: stable closed loop always fast, else the selected one
    assign use_slow = ramp_q[UPTIME_BIT] && !(at_stable && closed_loop); // R13 R15
    assign run_tick = use_slow ? slow_if.tick : fast_if.tick;
    assign run_tgt = {target_duty, {FRAC_W{1'b0}}};
    assign gap = (duty_q > run_tgt) ? duty_q - run_tgt : run_tgt - duty_q;
    assign soft_sum = {1'b0, duty_q} + {6'h00, ss_step};

    // next duty per phase
    always_comb begin
        duty_d = duty_q;
        case (st_q)
            ST_IDLE: begin
                if (spd_cmd && idling_fwd) begin
                    duty_d = idle_duty; // R9 R10
                end else begin
                    duty_d = '0; // R1
                end
            end
            ST_SOFT: begin
                // climb only while current stays under the startup limit
                if (fast_if.tick && !cur_sync2_q) begin
                    duty_d = soft_sum[DUTY_W] ? DUTY_MAX : soft_sum[DUTY_W-1:0]; // R1 R15
                end
            end
            ST_SENSL: begin
                if (run_tick) begin
                    if (limsel_q[RUNSTEP_LSB +: 3] == 3'h0 && !closed_loop) begin
                        duty_d = run_tgt; // R14
                    end else if (gap <= DUTY_W'(run_step)) begin
                        duty_d = run_tgt; // R12
                    end else if (duty_q < run_tgt) begin
                        duty_d = duty_q + DUTY_W'(run_step); // R12 R17
                    end else begin
                        duty_d = duty_q - DUTY_W'(run_step); // R12 R17
                    end
                end
            end
            default: duty_d = '0;
        endcase
        if (!spd_cmd) begin
            duty_d = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            duty_q <= '0;
        end else begin
            duty_q <= duty_d; // R17
        end
    end

    // drive phase
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= ST_IDLE;
        end else if (!spd_cmd) begin
            st_q <= ST_IDLE;
        end else begin
            case (st_q)
                ST_IDLE: st_q <= idling_fwd ? ST_SENSL : ST_SOFT; // R9
                ST_SOFT: st_q <= sensl_reached ? ST_SENSL : ST_SOFT;
                ST_SENSL: st_q <= ST_SENSL;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // current limit: startup fraction, then stepped ramp once sensorless
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            clim_q <= CLIM_FULL;
            ramp_wait_q <= 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    ramp_wait_q <= 1'b0;
                    clim_q <= (spd_cmd && idling_fwd) ? CLIM_FULL : start_lim; // R9 R16
                end
                ST_SOFT: begin
                    clim_q <= start_lim; // R16
                    ramp_wait_q <= sensl_reached; // R4
                end
                ST_SENSL: begin
                    if (clim_if.tick) begin
                        ramp_wait_q <= 1'b0; // R5
                        if (!ramp_wait_q && clim_q < ramp_cap) begin
                            // last step lands exactly on the capped target
                            clim_q <= (ramp_next > {1'b0, ramp_cap}) ? ramp_cap
                                : ramp_next[9:0]; // R4 R5 R6
                        end
                    end
                end
                default: clim_q <= CLIM_FULL;
            endcase
        end
    end

    assign reg_rdata = rdata_q;
    assign duty_out = duty_q[DUTY_W-1:FRAC_W];
    assign cur_limit = clim_q;
    assign drive_state = st_q;
endmodule

// File: sim/mdr_props.sv
`timescale 1ns/10ps
// port-level watch on the ramp core
module mdr_props (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic spd_cmd,
    input wire logic idling_fwd,
    input wire logic sensl_reached,
    input wire logic [8:0] duty_out,
    input wire logic [9:0] cur_limit,
    input wire logic [1:0] drive_state
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // start phases and limit step; spd_cmd guards the start phases because a stop overrides everything
    sequence s_cold;
        drive_state == 2'b00 && spd_cmd && !idling_fwd;
    endsequence
    sequence s_warm;
        drive_state == 2'b00 && spd_cmd && idling_fwd;
    endsequence
    sequence s_soft;
        drive_state == 2'b01 && spd_cmd && !sensl_reached;
    endsequence
    sequence s_lim_step;
        drive_state == 2'b11 && $changed(cur_limit);
    endsequence
    // read data only in the cycle after a read strobe
    a_rd_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not quiet");
    a_stop_idle: assert property (!spd_cmd |=> drive_state == 2'b00 && duty_out == 9'h000)
        else $error("stop did not idle");
    a_soft_zero: assert property (s_cold |=> drive_state == 2'b01 && duty_out == 9'h000)
        else $error("soft start not from zero");
    a_warm_norm: assert property (s_warm |=> drive_state == 2'b11 && cur_limit == 10'h3e8)
        else $error("idling start wrong");
    a_soft_rise: assert property (s_soft |=> duty_out >= $past(duty_out)
        && duty_out <= $past(duty_out) + 10'h008) else $error("soft duty step wrong");
    a_soft_lim: assert property (s_soft |=> $stable(cur_limit))
        else $error("startup limit moved");
    a_sensl_go: assert property (drive_state == 2'b01 && spd_cmd && sensl_reached
        |=> drive_state == 2'b11) else $error("sensorless not entered");
    a_lim_cap: assert property (cur_limit <= 10'h3e8)
        else $error("limit above normal");
    a_lim_rise: assert property (drive_state == 2'b11 && spd_cmd
        |=> cur_limit >= $past(cur_limit)) else $error("limit dropped");
    a_lim_gap: assert property (s_lim_step |=> ($stable(cur_limit) || drive_state != 2'b11)[*8])
        else $error("limit steps too close");
endmodule
bind mdr_core mdr_props u_mdr_props (.sys_clk, .nrst, .reg_rd, .reg_rdata, .spd_cmd,
    .idling_fwd, .sensl_reached, .duty_out, .cur_limit, .drive_state);

// File: sim/motor_duty_ramp_softstart_test.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end
module motor_duty_ramp_softstart_test;
    import mdr_pkg::*;
    // short timers keep the run small; the soft, ramp and run waits derive from them
    localparam int FAST = 20;
    localparam int SLOW = 80;
    localparam int CLIM = 200;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic spd_cmd = 1'b0;
    logic idling_fwd = 1'b0;
    logic [15:0] idle_rpm = 16'h0bb8;
    logic sensl_reached = 1'b0;
    logic at_stable = 1'b0;
    logic closed_loop = 1'b0;
    logic [8:0] target_duty = 9'h000;
    logic cur_hit_pin = 1'b0;
    logic [8:0] duty_out;
    logic [9:0] cur_limit;
    logic [1:0] drive_state;
    logic [8:0] d;
    int n;
    int n_errors = 0;
    int total_checks = 0;
    // eight soft ticks land the duty exactly on the step size in eighths
    logic [8:0] soft_tbl [8] = '{9'h040, 9'h002, 9'h003, 9'h004, 9'h006, 9'h00a, 9'h014, 9'h038};

    mdr_core #(.FAST_CYCLES(FAST), .SLOW_CYCLES(SLOW), .CLIM_CYCLES(CLIM)) u_mdr_core (
        .sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .spd_cmd, .idling_fwd, .idle_rpm, .sensl_reached, .at_stable, .closed_loop,
        .target_duty, .cur_hit_pin, .duty_out, .cur_limit, .drive_state);

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    task automatic finish_test();
        if (n_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // register bus: one-cycle strobes, read data taken in the following cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        `CHK(reg_rdata, e)
    endtask

    task automatic start(input logic fwd);
        @(posedge sys_clk);
        idling_fwd <= fwd;
        spd_cmd <= 1'b1;
    endtask

    task automatic stop();
        @(posedge sys_clk);
        spd_cmd <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(duty_out, 9'h000)
        `CHK(drive_state, 2'b00)
    endtask

    // cycles until duty_out next moves; bounded so a stuck duty cannot hang
    task automatic meas();
        d = duty_out;
        n = 0;
        while (duty_out === d && n < 1000) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic soft_run(input logic [7:0] en, input logic [2:0] c, input logic [8:0] e);
        wr(REG_CTRL, en);
        wr(REG_RAMP, {4'h0, c, 1'b0});
        start(1'b0);
        repeat (8 * FAST + 10) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(duty_out, e)
        `CHK(cur_limit, 10'h1f4)
        stop();
    endtask

    // first change must skip one ramp tick, then the limit settles on its target
    task automatic ramp_run(input logic [7:0] ls, input logic [7:0] rp,
        input logic [9:0] st, input logic [9:0] fst, input logic [9:0] lst);
        wr(REG_LIMSEL, ls);
        wr(REG_RAMP, rp);
        start(1'b0);
        repeat (5) @(posedge sys_clk);
        sensl_reached <= 1'b1;
        @(posedge sys_clk);
        sensl_reached <= 1'b0;
        @(negedge sys_clk);
        `CHK(drive_state, 2'b11)
        `CHK(cur_limit, st)
        n = 0;
        while (cur_limit === st && n < 3 * CLIM) begin
            @(negedge sys_clk);
            n++;
        end
        `CHK(n >= CLIM, 1'b1)
        `CHK(cur_limit, fst)
        repeat (16 * CLIM) @(negedge sys_clk);
        `CHK(cur_limit, lst)
        stop();
    endtask

    // watchdog, well beyond the expected run length
    initial begin
        repeat (40000) @(posedge sys_clk);
        n_errors++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        @(negedge sys_clk);
        `CHK(cur_limit, 10'h3e8)
        `CHK(duty_out, 9'h000)
        rdc(REG_RAMP, 8'h00);
        wr(REG_RAMP, 8'ha5);
        rdc(REG_RAMP, 8'ha5);
        rdc(8'h7f, 8'h00);
        wr(REG_DUTY, 8'hff);
        rdc(REG_DUTY, 8'h00);
        wr(REG_LIMSEL, 8'h08);
        rdc(REG_LIMSEL, 8'h08);
        for (int c = 0; c < 8; c++) begin
            soft_run(8'h01, 3'(c), soft_tbl[c]);
        end
        soft_run(8'h00, 3'h1, 9'h040);
        // a current hit freezes the climb
        start(1'b0);
        repeat (2 * FAST + 10) @(posedge sys_clk);
        cur_hit_pin <= 1'b1;
        repeat (4 * FAST) @(posedge sys_clk);
        cur_hit_pin <= 1'b0;
        @(negedge sys_clk);
        `CHK(duty_out, 9'h010)
        stop();
        ramp_run(8'h02, 8'hf0, 10'h36b, 10'h3cf, 10'h3e8);
        ramp_run(8'h08, 8'ha0, 10'h1f4, 10'h226, 10'h384);
        ramp_run(8'h0e, 8'h50, 10'h07d, 10'h091, 10'h1a9);
        ramp_run(8'h08, 8'h00, 10'h1f4, 10'h1f4, 10'h1f4);
        for (int s = 0; s < 4; s++) begin
            wr(REG_TOPSPD, 8'(s << 1));
            start(1'b1);
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            `CHK(drive_state, 2'b11)
            `CHK(cur_limit, 10'h3e8)
            `CHK(duty_out, 9'((3000 * 512 / (4096 << s)) / 2))
            stop();
        end
        // sensorless run: slow interval, then fast at stable speed, then code zero
        wr(REG_LIMSEL, 8'h78);
        wr(REG_RAMP, 8'h01);
        closed_loop <= 1'b1;
        target_duty <= 9'h1ff;
        start(1'b1);
        meas();
        meas();
        meas();
        `CHK(n, SLOW)
        `CHK(duty_out, d + 9'h007)
        @(posedge sys_clk);
        at_stable <= 1'b1;
        meas();
        meas();
        `CHK(n, FAST)
        wr(REG_LIMSEL, 8'h08);
        meas();
        meas();
        `CHK(duty_out, d + 9'h008)
        @(posedge sys_clk);
        closed_loop <= 1'b0;
        target_duty <= 9'h064;
        meas();
        `CHK(duty_out, 9'h064)
        stop();
        finish_test();
    end
endmodule
